// file: fes_map.svh
// Register offsets, field positions, masks and reset values of the
// float exception status block. Assumes byte addresses on a 12-bit APB.
`ifndef FES_MAP_SVH
`define FES_MAP_SVH
`define FES_OFF_FSC    12'h000
`define FES_OFF_MSR    12'h004
`define FES_OFF_CMD    12'h008
`define FES_B_FX       0
`define FES_B_FEX      1
`define FES_B_VX       2
`define FES_B_OX       3
`define FES_B_UX       4
`define FES_B_ZX       5
`define FES_B_XX       6
`define FES_B_SNAN     7
`define FES_B_ISI      8
`define FES_B_IDI      9
`define FES_B_ZDZ      10
`define FES_B_IMZ      11
`define FES_B_VC       12
`define FES_B_FR       13
`define FES_B_FI       14
`define FES_B_SOFT     21
`define FES_B_SQRT     22
`define FES_B_CVI      23
`define FES_B_VE       24
`define FES_B_OE       25
`define FES_B_UE       26
`define FES_B_ZE       27
`define FES_B_XE       28
`define FES_B_NI       29
`define FES_B_FP       18
`define FES_B_FE0      20
`define FES_B_FE1      23
`define FES_CMD_SET    8
`define FES_CMD_IDX_HI 4
`define FES_FSC_WMASK  32'h3fe07ff9
`define FES_EXC_MASK   32'h00e01ff8
`define FES_INV_MASK   32'h00e01f80
`define FES_MSR_WMASK  32'h00940000
`define FES_RST_FSC    32'h00000000
`define FES_RST_MSR    32'h00000000
`endif

// file: fes_pkg.sv
// Types shared by the float exception status block and its neighbours.
// Assumes the datapath reports one finished instruction per valid pulse.
package fes_pkg;
  // One completed float instruction as seen by the status logic
  typedef struct packed {
    logic valid;
    logic overflow;
    logic underflow;
    logic zero_divide;
    logic inexact;
    logic invalid_signaling_nan;
    logic invalid_inf_sub_inf;
    logic invalid_inf_div_inf;
    logic invalid_zero_div_zero;
    logic invalid_inf_mul_zero;
    logic invalid_compare;
    logic invalid_root;
    logic invalid_int_convert;
    logic round_incremented;
    logic fraction_inexact;
  } fes_report_s;
  // Copy of the summary bits for the condition field
  typedef struct packed {
    logic any_flag_summary;
    logic enabled_summary;
    logic invalid_summary;
    logic overflow_flag;
  } fes_cr1_s;
  // Interrupt mode, coded as {mode bit a, mode bit b}
  typedef enum logic [1:0] {
    FES_MODE_OFF     = 2'b00,
    FES_MODE_IMP_NR  = 2'b01,
    FES_MODE_IMP_R   = 2'b10,
    FES_MODE_PRECISE = 2'b11
  } fes_irq_mode_e;
endpackage

// file: fes_float_exception_status.sv
// Float exception status and control with machine-state gating bits.
// Assumes an APB master on pclk and a datapath that reports results
// synchronously, one valid pulse per completed float instruction.
// Notes on behaviour
// - Available bit 18 gates float execution
// - Mode bits 20, 23 select interrupt kind
// - Bit 0 sets on any new exception
// - Bit 1 shows enabled exception present
// - Bit 2 shows any invalid bit set
// - Bit 3 sets on overflow
// - Bit 6 sticky inexact, stays set
// - Bit 7 sets on signaling NaN input
// - Bit 8 sets on infinity minus infinity
// - Bit 9 sets on infinity over infinity
// - Bit 10 sets on zero over zero
// - Bit 11 sets on infinity times zero
// - Bit 12 sets on ordered compare NaN
// - Bit 13 shows fraction was incremented
// - Bit 14 live inexact or disabled overflow
// - Bit 21 set by software status writes
// - Bit 22 sets on invalid square root
// - Bit 23 sets on bad integer convert
// - Bit 24 enables invalid interrupt
// - Bit 25 enables overflow interrupt
// - Bit 28 enables inexact interrupt
// - Bit 29 selects non-IEEE mode
// - Bit 4 sets on underflow
// - Bit 5 sets on zero divide
// - Bit 26 enables underflow interrupt
// - Bit 27 enables zero-divide interrupt
`timescale 1ns/1ps
`include "fes_map.svh"

module fes_float_exception_status (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Datapath exception reports
  input  wire fes_pkg::fes_report_s  report,
  // Instruction issue gating
  input  wire logic                  issue_req,
  output logic                       issue_grant,
  output logic                       unavail_trap,
  // Status toward sequencer and condition field
  output fes_pkg::fes_cr1_s          compare_field_one,
  output fes_pkg::fes_irq_mode_e     irq_mode,
  output logic                       float_unit_available,
  output logic                       non_ieee_switch,
  output logic                       program_irq
);
  import fes_pkg::*;

  localparam logic [31:0] FSC_WMASK = `FES_FSC_WMASK;
  localparam logic [31:0] EXC_MASK  = `FES_EXC_MASK;
  localparam logic [31:0] INV_MASK  = `FES_INV_MASK;
  localparam logic [31:0] MSR_WMASK = `FES_MSR_WMASK;

  // Stored state
  logic [31:0]   fsc_q;
  logic [31:0]   fsc_d;
  logic [31:0]   msr_q;
  logic [31:0]   msr_d;
  logic [31:0]   prdata_q;
  logic          pslverr_q;
  logic          irq_q;
  logic          trap_q;
  fes_cr1_s      cr1_q;
  fes_irq_mode_e mode_q;

  // Bus decode
  logic          setup_ph;
  logic          access_ph;
  logic          sel_fsc;
  logic          sel_msr;
  logic          sel_cmd;
  logic          addr_bad;
  logic          wr_fsc;
  logic          wr_msr;
  logic          wr_cmd;
  logic [31:0]   lane_m;
  logic [4:0]    cmd_idx;

  // Datapath side
  logic          rep_take;
  logic          fi_live;
  logic [31:0]   hw_set;
  logic [31:0]   rise;

  // Any invalid-operation cause present in a word
  function automatic logic fes_invalid_any(input logic [31:0] w);
    return |(w & INV_MASK);
  endfunction

  // Enabled summary: each class flag gated by its enable
  function automatic logic fes_enabled_any(input logic [31:0] w);
    logic vx;
    vx = fes_invalid_any(w);
    return (vx & w[`FES_B_VE]) |
           (w[`FES_B_OX] & w[`FES_B_OE]) |
           (w[`FES_B_UX] & w[`FES_B_UE]) |
           (w[`FES_B_ZX] & w[`FES_B_ZE]) |
           (w[`FES_B_XX] & w[`FES_B_XE]);
  endfunction

  // Software-visible word: stored bits plus the two derived summaries
  function automatic logic [31:0] fes_view(input logic [31:0] w);
    logic [31:0] v;
    v = w;
    v[`FES_B_FEX] = fes_enabled_any(w);
    v[`FES_B_VX]  = fes_invalid_any(w);
    return v;
  endfunction

  // Byte-lane write mask from APB strobes
  function automatic logic [31:0] fes_lane_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // APB phases; zero wait states so pready stays high
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready    = 1'b1;
  assign lane_m    = fes_lane_mask(pstrb);
  assign cmd_idx   = pwdata[`FES_CMD_IDX_HI:0];

  // Address decode; anything else, unaligned included, is an error
  always_comb begin
    sel_fsc  = 1'b0;
    sel_msr  = 1'b0;
    sel_cmd  = 1'b0;
    addr_bad = 1'b0;
    if (paddr == `FES_OFF_FSC) begin
      sel_fsc = 1'b1;
    end else if (paddr == `FES_OFF_MSR) begin
      sel_msr = 1'b1;
    end else if (paddr == `FES_OFF_CMD) begin
      sel_cmd = 1'b1;
    end else begin
      addr_bad = 1'b1;
    end
  end

  // Writes land only at the access edge
  assign wr_fsc = access_ph & pwrite & sel_fsc;
  assign wr_msr = access_ph & pwrite & sel_msr;
  // Bit command needs index and set lanes both strobed
  assign wr_cmd = access_ph & pwrite & sel_cmd & pstrb[0] & pstrb[1];

  // Reports are ignored while the float unit is unavailable
  assign rep_take = report.valid & msr_q[`FES_B_FP];

  // A disabled overflow also counts as an inexact result
  assign fi_live = report.fraction_inexact |
                   (report.overflow & ~fsc_q[`FES_B_OE]);

  // Exception bits raised by the datapath this cycle
  always_comb begin
    hw_set = 32'h00000000;
    if (rep_take) begin
      hw_set[`FES_B_OX]   = report.overflow;
      hw_set[`FES_B_UX]   = report.underflow;
      hw_set[`FES_B_ZX]   = report.zero_divide;
      hw_set[`FES_B_XX]   = fi_live;
      hw_set[`FES_B_SNAN] = report.invalid_signaling_nan;
      hw_set[`FES_B_ISI]  = report.invalid_inf_sub_inf;
      hw_set[`FES_B_IDI]  = report.invalid_inf_div_inf;
      hw_set[`FES_B_ZDZ]  = report.invalid_zero_div_zero;
      hw_set[`FES_B_IMZ]  = report.invalid_inf_mul_zero;
      hw_set[`FES_B_VC]   = report.invalid_compare;
      hw_set[`FES_B_SQRT] = report.invalid_root;
      hw_set[`FES_B_CVI]  = report.invalid_int_convert;
    end
  end

  // Next status word; hardware sets are applied after software so
  // an event in the same cycle as a clear is never lost
  always_comb begin
    logic [31:0] m;
    logic [31:0] nxt;
    m   = lane_m & FSC_WMASK;
    nxt = fsc_q;
    if (wr_fsc) begin
      nxt = (pwdata & m) | (fsc_q & ~m);
    end
    if (wr_cmd && FSC_WMASK[cmd_idx]) begin
      nxt[cmd_idx] = pwdata[`FES_CMD_SET];
    end
    nxt = nxt | hw_set;
    // Live indicators describe only the latest instruction
    if (rep_take) begin
      nxt[`FES_B_FR] = report.round_incremented;
      nxt[`FES_B_FI] = fi_live;
    end
    // Summary catches any 0 to 1 step of an exception bit
    rise = nxt & ~fsc_q & EXC_MASK;
    if (|rise) begin
      nxt[`FES_B_FX] = 1'b1;
    end
    // Derived summaries are never stored
    nxt[`FES_B_FEX] = 1'b0;
    nxt[`FES_B_VX]  = 1'b0;
    fsc_d = nxt;
  end

  // Status word storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsc_q <= `FES_RST_FSC;
    end else begin
      fsc_q <= fsc_d;
    end
  end

  // Machine state: only the available and mode bits exist
  always_comb begin
    logic [31:0] m;
    m     = lane_m & MSR_WMASK;
    msr_d = msr_q;
    if (wr_msr) begin
      msr_d = (pwdata & m) | (msr_q & ~m);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msr_q <= `FES_RST_MSR;
    end else begin
      msr_q <= msr_d;
    end
  end

  // Interrupt mode decoded from the two machine-state bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= FES_MODE_OFF;
    end else begin
      mode_q <= fes_irq_mode_e'({msr_d[`FES_B_FE0],
                                 msr_d[`FES_B_FE1]});
    end
  end

  // Program interrupt level; mode off keeps it low even with flags set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= fes_enabled_any(fsc_d) &
               ({msr_d[`FES_B_FE0], msr_d[`FES_B_FE1]} != 2'b00);
    end
  end

  // Condition field copy, kept in step with the status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cr1_q <= '0;
    end else begin
      cr1_q.any_flag_summary <= fsc_d[`FES_B_FX];
      cr1_q.enabled_summary  <= fes_enabled_any(fsc_d);
      cr1_q.invalid_summary  <= fes_invalid_any(fsc_d);
      cr1_q.overflow_flag    <= fsc_d[`FES_B_OX];
    end
  end

  // Issue attempted with the unit unavailable raises the trap one cycle later, for each cycle the request is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_q <= 1'b0;
    end else begin
      trap_q <= issue_req & ~msr_q[`FES_B_FP];
    end
  end

  assign issue_grant = issue_req & msr_q[`FES_B_FP];

  // Read data is captured in the setup cycle so it comes from a flop;
  // a datapath event landing between setup and access shows next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      pslverr_q <= addr_bad;
      if (pwrite || !(sel_fsc || sel_msr)) begin
        prdata_q <= 32'h00000000;
      end else if (sel_fsc) begin
        prdata_q <= fes_view(fsc_q);
      end else begin
        prdata_q <= msr_q;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & access_ph;

  // Outputs toward the sequencer
  assign compare_field_one    = cr1_q;
  assign irq_mode             = mode_q;
  assign float_unit_available = msr_q[`FES_B_FP];
  assign non_ieee_switch      = fsc_q[`FES_B_NI];
  assign program_irq          = irq_q;
  assign unavail_trap         = trap_q;

endmodule

// file: fes_float_exception_status_chk.sv
// Checker for the float exception status block, bound to its ports.
// Assumes a single pclk domain with asynchronous active-low presetn.
`timescale 1ns/1ps
module fes_float_exception_status_chk (
  // Clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // APB
  input wire logic                   psel,
  input wire logic                   pwrite,
  // Datapath side
  input wire fes_pkg::fes_report_s   report,
  input wire logic                   issue_req,
  input wire logic                   issue_grant,
  input wire logic                   unavail_trap,
  // Status outputs
  input wire fes_pkg::fes_cr1_s      compare_field_one,
  input wire fes_pkg::fes_irq_mode_e irq_mode,
  input wire logic                   float_unit_available,
  input wire logic                   program_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Software writes may clear flags, so sticky checks skip them
  a_grant_gate: assert property (issue_grant == (issue_req && float_unit_available))
    else $error("issue grant not gated by availability");
  a_trap_pulse: assert property (issue_req && !float_unit_available |=> unavail_trap)
    else $error("no trap for issue while unavailable");
  a_gate_reports: assert property (report.valid && !float_unit_available && !psel
    |=> $stable(compare_field_one)) else $error("report taken while unavailable");
  a_ovf_sets: assert property (report.valid && report.overflow && float_unit_available
    |=> compare_field_one.overflow_flag && compare_field_one.any_flag_summary)
    else $error("overflow report not recorded");
  a_inv_summary: assert property (report.valid && float_unit_available
    && (report.invalid_root || report.invalid_compare) |=> compare_field_one.invalid_summary)
    else $error("invalid summary missing");
  a_ovf_sticky: assert property (compare_field_one.overflow_flag && !(psel && pwrite)
    |=> compare_field_one.overflow_flag) else $error("overflow flag lost");
  a_any_sticky: assert property (compare_field_one.any_flag_summary && !(psel && pwrite)
    |=> compare_field_one.any_flag_summary) else $error("any summary lost");
  a_irq_cause: assert property ($rose(program_irq) |-> compare_field_one.enabled_summary
    && irq_mode != fes_pkg::FES_MODE_OFF) else $error("interrupt without cause");
endmodule
bind fes_float_exception_status fes_float_exception_status_chk u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .pwrite(pwrite), .report(report), .issue_req(issue_req),
  .issue_grant(issue_grant), .unavail_trap(unavail_trap), .compare_field_one(compare_field_one),
  .irq_mode(irq_mode), .float_unit_available(float_unit_available), .program_irq(program_irq));

// file: fes_dp_model.sv
// Datapath stand-in: turns one-cycle bench requests into report pulses.
// Assumes the bench drives fire, flags and want just after pclk edges.
`timescale 1ns/1ps
module fes_dp_model (
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // Bench commands
  input  wire logic            fire,
  input  wire logic [13:0]     flags,
  input  wire logic            want,
  // Toward the status block
  output fes_pkg::fes_report_s report,
  output logic                 issue_req
);
  // Registered like a pipeline stage; flags are zero outside a pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      report    <= '0;
      issue_req <= 1'b0;
    end else begin
      report    <= fire ? {1'b1, flags} : 15'h0000;
      issue_req <= want;
    end
  end
endmodule

// file: fes_float_exception_status_tb.sv
// Self-checking bench: APB register tasks plus datapath report pulses.
// Assumes the datapath model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "fes_map.svh"
module fes_float_exception_status_tb;
  import fes_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb;
  logic        fire, want, issue_req, issue_grant, unavail_trap, avail, ni, irq, rerr;
  logic [13:0] flags;
  fes_report_s report;
  fes_cr1_s    cr1;
  fes_irq_mode_e mode;
  int          err_total, n_checks;
  // One-hot report kinds and the status word each leaves behind
  localparam logic [13:0] KF [13] = '{14'h2000, 14'h1000, 14'h0800, 14'h0200, 14'h0100,
    14'h0080, 14'h0040, 14'h0020, 14'h0010, 14'h0008, 14'h0004, 14'h0002, 14'h0001};
  localparam logic [31:0] KW [13] = '{32'h00004049, 32'h00000011, 32'h00000021,
    32'h00000085, 32'h00000105, 32'h00000205, 32'h00000405, 32'h00000805, 32'h00001005,
    32'h00400005, 32'h00800005, 32'h00002000, 32'h00004041};
  // Enable word, matching report, expected interrupt
  localparam logic [31:0] EN [6] = '{32'h01000000, 32'h02000000, 32'h04000000,
    32'h08000000, 32'h10000000, 32'h00000000};
  localparam logic [13:0] EF [6] = '{14'h0200, 14'h2000, 14'h1000, 14'h0800, 14'h0001,
    14'h2000};
  localparam logic [31:0] MV [4] = '{32'h00040000, 32'h00840000, 32'h00140000, 32'h00940000};

  fes_float_exception_status DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .report(report),
    .issue_req(issue_req), .issue_grant(issue_grant), .unavail_trap(unavail_trap),
    .compare_field_one(cr1), .irq_mode(mode), .float_unit_available(avail),
    .non_ieee_switch(ni), .program_irq(irq));
  fes_dp_model u_dp (.pclk(pclk), .presetn(presetn), .fire(fire), .flags(flags),
    .want(want), .report(report), .issue_req(issue_req));

  // Free-running bus clock
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  task results;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Setup then access; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // Pulse lands two edges later; sample after the taking edge settles
  task send(input logic [13:0] f);
    @(posedge pclk);
    fire <= 1'b1; flags <= f;
    @(posedge pclk);
    fire <= 1'b0;
    @(posedge pclk);
    #1;
  endtask
  task issue(input logic [31:0] g);
    @(posedge pclk);
    want <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk({31'h0, issue_grant}, g);
    @(posedge pclk);
    #1 chk({31'h0, unavail_trap}, ~g & 32'h1);
    @(posedge pclk);
    want <= 1'b0;
  endtask

  // Hang guard, far beyond the few hundred cycles of the tests
  initial begin
    #100000;
    err_total++;
    results();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'hf; fire = 1'b0; flags = 14'h0; want = 1'b0;
    err_total = 0; n_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`FES_OFF_FSC, 32'h0);
    rdc(`FES_OFF_MSR, 32'h0);
    send(14'h2000);
    rdc(`FES_OFF_FSC, 32'h0);
    issue(32'h0);
    apb(1'b1, `FES_OFF_MSR, 32'hffffffff);
    rdc(`FES_OFF_MSR, 32'h00940000);
    chk({30'h0, mode}, 32'h3);
    apb(1'b1, `FES_OFF_FSC, 32'hffffffff);
    rdc(`FES_OFF_FSC, 32'h3fe07fff);
    chk({31'h0, ni}, 32'h1);
    for (int i = 0; i < 13; i++) begin
      apb(1'b1, `FES_OFF_FSC, 32'h0);
      send(KF[i]);
      rdc(`FES_OFF_FSC, KW[i]);
    end
    send(14'h0);
    rdc(`FES_OFF_FSC, 32'h00000041);
    apb(1'b1, `FES_OFF_FSC, 32'h0);
    apb(1'b1, `FES_OFF_CMD, 32'h00000115);
    rdc(`FES_OFF_FSC, 32'h00200005);
    apb(1'b1, `FES_OFF_CMD, 32'h00000015);
    rdc(`FES_OFF_FSC, 32'h00000001);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `FES_OFF_FSC, EN[i]);
      send(EF[i]);
      chk({31'h0, irq}, (i < 5) ? 32'h1 : 32'h0);
      apb(1'b0, `FES_OFF_FSC, 32'h0);
      chk({31'h0, rdat[1]}, (i < 5) ? 32'h1 : 32'h0);
      // Clearing write leaves nothing behind for the next pass
      apb(1'b1, `FES_OFF_FSC, 32'h0);
      rdc(`FES_OFF_FSC, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `FES_OFF_MSR, MV[i]);
      apb(1'b1, `FES_OFF_FSC, 32'h02000000);
      send(14'h2000);
      chk({30'h0, mode}, i);
      chk({31'h0, irq}, (i != 0) ? 32'h1 : 32'h0);
    end
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    issue(32'h1);
    results();
  end
endmodule
